/* phy_ctrl_map.svh */
`ifndef PHY_CTRL_MAP_SVH
`define PHY_CTRL_MAP_SVH
// register indices (5-bit management addresses)
`define REG_CONTROL      5'h00
`define REG_ADVERT       5'h04
`define REG_AUX_STATUS   5'h18
`define REG_IRQ_OUT_N         5'h1a
`define REG_AUX_MODE2    5'h1b
`define REG_MULTI_PHY    5'h1e
// control register fields
`define CTL_RESET_BIT    15
`define CTL_LOOPBACK_BIT 14
`define CTL_ANEG_BIT     12
`define CTL_ISOLATE_BIT  10
`define CTL_DUPLEX_BIT   8
`define CTL_COLTEST_BIT  7
`define CTL_RESET_VAL    16'h1000
// advertisement: full-duplex abilities bits 8 and 6
`define ADV_RESET_VAL    16'h01e1
`define ADV_FDX_MASK     16'h0140
// interrupt register fields
`define INT_STATUS_BIT   0
`define INT_DUPLEX_BIT   1
`define INT_SPEED_BIT    2
`define INT_LINK_BIT     3
`define INT_LEDMODE_LO   4
`define INT_LEDMODE_HI   5
`define INT_GMASK_BIT    8
`define INT_DMASK_BIT    9
`define INT_SMASK_BIT    10
`define INT_LMASK_BIT    11
`define INT_ENABLE_BIT   14
`define INT_DUPLEX_LED_N_BIT   15
`define LED_FORCE_ON     2'h1
`define LED_FORCE_OFF    2'h2
// aux mode 2 / multi-phy fields
`define AM2_TRAFFIC_BIT  6
`define MP_SERIAL_BIT    1
`define MP_SUPER_ISO_BIT 3
// timing
`define CLK_PERIOD_NS    50
`define RESET_MIN_US     20
`define RESET_MIN_CYC    ((`RESET_MIN_US*1000+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define LED_PULSE_MS     80
`define LED_PULSE_CYC    ((`LED_PULSE_MS*1000000)/`CLK_PERIOD_NS)
`define TRAFFIC_DIV      8
`define MII10_DIV        4
`define SER_DIV          1
`endif

/* phy_ctrl_pkg.sv */
package phy_ctrl_pkg;
  typedef logic [4:0]  reg_addr_t;
  typedef logic [15:0] reg_data_t;
  typedef enum logic [1:0] {SPD_10, SPD_100TX, SPD_100FX} speed_t;
endpackage

/* phy_mode_ctrl.sv */
// Local design decisions: the address-and-strobe port and the register offsets.
`include "phy_ctrl_map.svh"
`timescale 1ns/10ps
`default_nettype none
module phy_mode_ctrl
  import phy_ctrl_pkg::*;
#(
  parameter int unsigned LED_PULSE_CYC = `LED_PULSE_CYC
) (
  input  wire logic               sys_clk_i,
  input  wire logic               reset_i,
  input  wire phy_ctrl_pkg::reg_addr_t reg_addr_i,
  input  wire phy_ctrl_pkg::reg_data_t reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic [15:0]             reg_rdata_o,
  input  wire logic               duplex_strap_i,
  input  wire logic               fiber_signal_detect_i,
  input  wire logic               link_up_i,
  input  wire logic               speed100_i,
  input  wire logic               aneg_duplex_i,
  input  wire logic [3:0]         mii_txd_i,
  input  wire logic               mii_tx_en_i,
  input  wire logic               mii_tx_er_i,
  input  wire logic [3:0]         line_rxd_i,
  input  wire logic               line_rx_dv_i,
  input  wire logic               line_rx_er_i,
  input  wire logic               line_col_i,
  output logic [3:0]              mii_rxd_o,
  output logic                    mii_rx_dv_o,
  output logic                    mii_rx_er_o,
  output logic                    mii_crs_o,
  output logic                    mii_col_o,
  output logic                    mii_tx_clk_o,
  output logic                    mii_rx_clk_o,
  output logic                    mii_out_oe_n_o,
  output logic [3:0]              line_txd_o,
  output logic                    line_tx_en_o,
  output logic                    line_tx_pair_oe_n_o,
  output logic                    fx_mode_o,
  output logic                    nrzi_coding_o,
  output logic                    scrambler_bypass_o,
  output logic                    manchester_o,
  output logic                    serial_mode_o,
  output logic                    duplex_full_o,
  output logic                    soft_reset_o,
  output logic                    tx_activity_led_n_o,
  output logic                    tx_activity_led_oe_n_o,
  output logic                    rx_activity_led_n_o,
  output logic                    speed_led_n_o,
  output logic                    link_led_n_o,
  output logic                    collision_led_n_o
);
  import phy_ctrl_pkg::*;

  logic [2:0]  sd_sync;
  logic        fiber_sd;
  reg_data_t   control;
  reg_data_t   advert;
  reg_data_t   irq_out_n;
  reg_data_t   aux_mode2;
  reg_data_t   multi_phy;
  logic        strap_dup;
  logic        any_reset;
  logic        full_dup;
  logic        loopback;
  logic        isolate;
  logic        serial_en;
  logic [2:0]  prev_state;
  logic [2:0]  changed;
  logic [2:0]  src_mask;
  logic [2:0]  set_bits;
  logic        wr_irq_out_n;
  logic        rd_irq_out_n;
  logic [3:0]  clk_div;
  logic        tx_clk_r;
  logic        rx_clk_r;
  logic [31:0] tx_led_cnt;
  logic [31:0] rx_led_cnt;
  logic [3:0]  meter_cnt;
  logic        meter_tick;
  logic        tx_led_on;
  logic        rx_led_on;
  logic        act_on;
  logic        rx_active;
  logic [1:0]  led_mode;

  // signal-detect synchroniser, change accepted when stages 2 and 3 agree
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sd_sync  <= 3'h0;
      fiber_sd <= 1'b0;
    end else begin
      sd_sync <= {sd_sync[1:0], fiber_signal_detect_i};
      if (sd_sync[2] == sd_sync[1])
        fiber_sd <= sd_sync[2];
    end
  end

  // duplex strap resampled every cycle while signal detect stages 2 and 3 are low and fiber mode is off
  always_ff @(posedge sys_clk_i) begin
    if (reset_i)
      strap_dup <= 1'b0;
    else if (sd_sync[2:1] == 2'h0 && !fx_mode_o)
      strap_dup <= duplex_strap_i;
  end

  assign soft_reset_o = reg_wr_i && reg_addr_i == `REG_CONTROL &&
                        reg_wdata_i[`CTL_RESET_BIT];
  assign any_reset    = reset_i || soft_reset_o;

  // control register; reset bit never stored, so it reads back 0
  always_ff @(posedge sys_clk_i) begin
    if (any_reset)
      control <= `CTL_RESET_VAL;
    else if (reg_wr_i && reg_addr_i == `REG_CONTROL)
      control <= reg_wdata_i & 16'h7fff;
  end

  // advertisement, full duplex advertised by default
  always_ff @(posedge sys_clk_i) begin
    if (any_reset)
      advert <= `ADV_RESET_VAL;
    else if (reg_wr_i && reg_addr_i == `REG_ADVERT)
      advert <= reg_wdata_i;
  end

  // mode registers
  always_ff @(posedge sys_clk_i) begin
    if (any_reset) begin
      aux_mode2 <= 16'h0000;
      multi_phy <= 16'h0000;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `REG_AUX_MODE2)
        aux_mode2 <= reg_wdata_i;
      if (reg_addr_i == `REG_MULTI_PHY)
        multi_phy <= reg_wdata_i;
    end
  end

  // duplex resolution
  always_comb begin
    if (control[`CTL_ANEG_BIT])
      full_dup = aneg_duplex_i && (advert & `ADV_FDX_MASK) != 16'h0000;
    else
      full_dup = strap_dup || control[`CTL_DUPLEX_BIT];
  end

  assign duplex_full_o      = full_dup;
  assign loopback           = control[`CTL_LOOPBACK_BIT];
  assign isolate            = control[`CTL_ISOLATE_BIT] ||
                              multi_phy[`MP_SUPER_ISO_BIT];
  assign fx_mode_o          = fiber_sd;
  assign nrzi_coding_o      = fiber_sd;
  assign scrambler_bypass_o = fiber_sd || !speed100_i;
  assign manchester_o       = !speed100_i && !fiber_sd;
  assign serial_en          = multi_phy[`MP_SERIAL_BIT] && manchester_o;
  assign serial_mode_o      = serial_en;

  // interrupt status: change detect, enable, per-source masks
  assign changed  = {link_up_i, speed100_i, full_dup} ^ prev_state;
  assign src_mask = {irq_out_n[`INT_LMASK_BIT], irq_out_n[`INT_SMASK_BIT],
                     irq_out_n[`INT_DMASK_BIT]};
  assign set_bits = irq_out_n[`INT_ENABLE_BIT] ? changed & ~src_mask
                                          : 3'h0;
  assign wr_irq_out_n  = reg_wr_i && reg_addr_i == `REG_IRQ_OUT_N;
  assign rd_irq_out_n  = reg_rd_i && reg_addr_i == `REG_IRQ_OUT_N;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i)
      prev_state <= 3'h0;
    else
      prev_state <= {link_up_i, speed100_i, full_dup};
  end

  // interrupt register; status clears on read, a new event wins
  always_ff @(posedge sys_clk_i) begin
    if (any_reset)
      irq_out_n <= 16'h0000;
    else begin
      if (wr_irq_out_n)
        irq_out_n[15:4] <= reg_wdata_i[15:4];
      if (rd_irq_out_n)
        irq_out_n[3:0] <= {set_bits, |set_bits};
      else
        irq_out_n[3:0] <= irq_out_n[3:0] | {set_bits, |set_bits};
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (reset_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `REG_CONTROL:    reg_rdata_o <= control;
        `REG_ADVERT:     reg_rdata_o <= advert;
        `REG_AUX_STATUS: reg_rdata_o <= {14'h0, speed100_i, full_dup};
        `REG_IRQ_OUT_N:       reg_rdata_o <= irq_out_n;
        `REG_AUX_MODE2:  reg_rdata_o <= aux_mode2;
        `REG_MULTI_PHY:  reg_rdata_o <= multi_phy;
        default:         reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  // mii clock generation: 2.5 MHz nibble, 10 MHz serial, 25 MHz unreachable
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      clk_div  <= 4'h0;
      tx_clk_r <= 1'b0;
    end else if (serial_en) begin
      clk_div  <= 4'h0;
      tx_clk_r <= ~tx_clk_r;
    end else if (clk_div == 4'(`MII10_DIV - 1)) begin
      clk_div  <= 4'h0;
      tx_clk_r <= ~tx_clk_r;
    end else
      clk_div  <= clk_div + 4'h1;
  end
  assign rx_clk_r     = tx_clk_r;
  assign mii_tx_clk_o = tx_clk_r;
  assign mii_rx_clk_o = rx_clk_r;

  // datapath: loopback, isolate, serial, duplex-dependent col/crs
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mii_rxd_o    <= 4'h0;
      mii_rx_dv_o  <= 1'b0;
      mii_rx_er_o  <= 1'b0;
      mii_crs_o    <= 1'b0;
      mii_col_o    <= 1'b0;
      line_txd_o   <= 4'h0;
      line_tx_en_o <= 1'b0;
    end else begin
      if (loopback) begin
        mii_rxd_o   <= isolate ? 4'h0 : mii_txd_i;
        mii_rx_dv_o <= !isolate && mii_tx_en_i;
        mii_rx_er_o <= !isolate && mii_tx_er_i;
      end else begin
        mii_rxd_o   <= serial_en ? {3'h0, line_rxd_i[0]}
                                 : line_rxd_i;
        mii_rx_dv_o <= line_rx_dv_i;
        mii_rx_er_o <= line_rx_er_i;
      end
      mii_crs_o <= (!loopback && line_rx_dv_i) ||
                   (!full_dup && !isolate && mii_tx_en_i);
      if (control[`CTL_COLTEST_BIT])
        mii_col_o <= !isolate && mii_tx_en_i;
      else
        mii_col_o <= !full_dup && !loopback && line_col_i;
      line_txd_o   <= (isolate || loopback) ? 4'h0 : mii_txd_i;
      line_tx_en_o <= !isolate && !loopback && mii_tx_en_i;
    end
  end
  assign mii_out_oe_n_o      = isolate;
  assign line_tx_pair_oe_n_o = multi_phy[`MP_SUPER_ISO_BIT];

  // traffic-meter divider tick
  always_ff @(posedge sys_clk_i) begin
    if (reset_i)
      meter_cnt <= 4'h0;
    else
      meter_cnt <= meter_cnt + 4'h1;
  end
  assign meter_tick = !aux_mode2[`AM2_TRAFFIC_BIT] ||
                      meter_cnt == 4'(`TRAFFIC_DIV - 1);

  // activity pulse stretchers, about 80 ms per burst in link pass, about 1280 ms with the traffic meter on (one tick per 16 cycles)
  assign rx_active = line_rx_dv_i && !loopback;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_led_cnt <= 32'h0;
      rx_led_cnt <= 32'h0;
    end else begin
      if (link_up_i && mii_tx_en_i && !isolate)
        tx_led_cnt <= 32'(LED_PULSE_CYC);
      else if (tx_led_cnt != 32'h0 && meter_tick)
        tx_led_cnt <= tx_led_cnt - 32'h1;
      if (link_up_i && rx_active)
        rx_led_cnt <= 32'(LED_PULSE_CYC);
      else if (rx_led_cnt != 32'h0 && meter_tick)
        rx_led_cnt <= rx_led_cnt - 32'h1;
    end
  end
  assign tx_led_on = tx_led_cnt != 32'h0;
  assign rx_led_on = rx_led_cnt != 32'h0;
  assign act_on    = tx_led_on || rx_led_on;
  assign led_mode  = {irq_out_n[`INT_LEDMODE_HI], irq_out_n[`INT_LEDMODE_LO]};

  // led / interrupt pin muxing, force modes override every led pin except tx activity while the interrupt is enabled
  always_comb begin
    tx_activity_led_oe_n_o = 1'b0;
    if (irq_out_n[`INT_ENABLE_BIT]) begin
      // open drain: drive low only while an unmasked interrupt is pending
      tx_activity_led_n_o    = 1'b0;
      tx_activity_led_oe_n_o = !(irq_out_n[`INT_STATUS_BIT] &&
                                 !irq_out_n[`INT_GMASK_BIT]);
      rx_activity_led_n_o    = !act_on;
    end else if (irq_out_n[`INT_DUPLEX_LED_N_BIT]) begin
      tx_activity_led_n_o = full_dup ? 1'b0 : 1'b1;
      rx_activity_led_n_o = !act_on;
    end else begin
      tx_activity_led_n_o = !tx_led_on;
      rx_activity_led_n_o = !rx_led_on;
    end
    speed_led_n_o     = !speed100_i;
    link_led_n_o      = !link_up_i;
    collision_led_n_o = !mii_col_o;
    if (led_mode == `LED_FORCE_ON) begin
      if (!irq_out_n[`INT_ENABLE_BIT])
        tx_activity_led_n_o = 1'b0;
      rx_activity_led_n_o = 1'b0;
      speed_led_n_o       = 1'b0;
      link_led_n_o        = 1'b0;
      collision_led_n_o   = 1'b0;
    end else if (led_mode == `LED_FORCE_OFF) begin
      if (!irq_out_n[`INT_ENABLE_BIT])
        tx_activity_led_n_o = 1'b1;
      rx_activity_led_n_o = 1'b1;
      speed_led_n_o       = 1'b1;
      link_led_n_o        = 1'b1;
      collision_led_n_o   = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* phy_mode_ctrl_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module phy_mode_ctrl_chk
  import phy_ctrl_pkg::*;
(
  input wire logic                    sys_clk_i,
  input wire logic                    reset_i,
  input wire phy_ctrl_pkg::reg_addr_t reg_addr_i,
  input wire phy_ctrl_pkg::reg_data_t reg_wdata_i,
  input wire logic                    reg_wr_i,
  input wire logic                    speed100_i,
  input wire logic                    soft_reset_o,
  input wire logic                    mii_out_oe_n_o,
  input wire logic                    line_tx_pair_oe_n_o,
  input wire logic                    duplex_full_o,
  input wire logic                    mii_col_o,
  input wire logic                    fx_mode_o,
  input wire logic                    nrzi_coding_o,
  input wire logic                    scrambler_bypass_o,
  input wire logic                    serial_mode_o,
  input wire logic                    manchester_o
);
  logic ctl_wr;
  // write strobe aimed at the control register
  assign ctl_wr = reg_wr_i && reg_addr_i == 5'h00;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // software reset pulses with a control write of bit 15, never with a 0
  soft_pulse_a: assert property (
    ctl_wr |-> soft_reset_o == reg_wdata_i[15])
    else $error("soft reset pulse wrong");
  iso_enter_a: assert property (ctl_wr && reg_wdata_i[10] && !reg_wdata_i[15] |=> mii_out_oe_n_o)
    else $error("isolate not entered");
  soft_iso_a: assert property (soft_reset_o |-> ##[0:2] !mii_out_oe_n_o)
    else $error("isolate survives reset");
  super_iso_a: assert property (line_tx_pair_oe_n_o |-> mii_out_oe_n_o)
    else $error("super isolate without mii float");
  fdx_col_a: assert property (duplex_full_o && $past(duplex_full_o, 2) |-> !mii_col_o)
    else $error("collision in full duplex");
  fx_coding_a: assert property (fx_mode_o |-> nrzi_coding_o && scrambler_bypass_o)
    else $error("fiber coding wrong");
  serial_10_a: assert property (serial_mode_o |-> !speed100_i && !fx_mode_o)
    else $error("serial mode at 100M");
  manch_code_a: assert property (manchester_o |-> !fx_mode_o && !nrzi_coding_o)
    else $error("manchester with fiber coding");
endmodule
bind phy_mode_ctrl phy_mode_ctrl_chk u_chk (.sys_clk_i, .reset_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .speed100_i, .soft_reset_o, .mii_out_oe_n_o,
  .line_tx_pair_oe_n_o, .duplex_full_o, .mii_col_o, .fx_mode_o,
  .nrzi_coding_o, .scrambler_bypass_o, .serial_mode_o, .manchester_o);
`default_nettype wire

/* mac_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mac_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [3:0] first_i,
  input  wire logic [3:0] len_i,
  output logic      [3:0] txd_o,
  output logic            tx_en_o,
  output logic            tx_er_o
);
  logic [3:0] left;
  // the mac never flags coding errors
  assign tx_er_o = 1'b0;
  // frame of len_i+1 counting nibbles; idle data toggles every cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      left <= 4'h0;
      txd_o <= 4'h0;
      tx_en_o <= 1'b0;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
      txd_o <= txd_o + 4'h1;
    end else if (start_i) begin
      left <= len_i;
      txd_o <= first_i;
      tx_en_o <= 1'b1;
    end else begin
      txd_o <= ~txd_o;
      tx_en_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* phy_mode_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "phy_ctrl_map.svh"
module phy_mode_ctrl_tb;
  import phy_ctrl_pkg::*;
  localparam int PULSE = 20;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  reg_addr_t reg_addr_i = 5'h00;
  reg_data_t reg_wdata_i = 16'h0000, d, reg_rdata_o;
  logic duplex_strap_i = 1'b0, fiber_signal_detect_i = 1'b0, link_up_i = 1'b0;
  logic speed100_i = 1'b0, aneg_duplex_i = 1'b0, line_rx_dv_i = 1'b0;
  logic line_rx_er_i = 1'b0, line_col_i = 1'b0, mac_start = 1'b0;
  logic [3:0] line_rxd_i = 4'h0, mac_first = 4'h0, mac_len = 4'h0;
  logic [3:0] mii_txd_i, mii_rxd_o, st, line_txd_o;
  logic mii_rx_er_o, mii_tx_clk_o, mii_rx_clk_o, ck;
  logic [4:0] leds;
  logic mii_tx_en_i, mii_tx_er_i, mii_rx_dv_o, mii_crs_o, mii_col_o;
  logic mii_out_oe_n_o, line_tx_en_o, line_tx_pair_oe_n_o, fx_mode_o;
  logic nrzi_coding_o, scrambler_bypass_o, manchester_o, serial_mode_o;
  logic duplex_full_o, soft_reset_o, tx_activity_led_n_o, tx_activity_led_oe_n_o;
  logic rx_activity_led_n_o, speed_led_n_o, link_led_n_o, collision_led_n_o;
  int bad_count = 0, compares = 0, cyc = 0, i, n;
  int unsigned seed;
  reg_data_t cfg [6] = '{16'h4000, 16'h4000, 16'h4800, 16'h4100, 16'h4900, 16'h0000};
  phy_mode_ctrl #(.LED_PULSE_CYC(PULSE)) dut (.sys_clk_i, .reset_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .duplex_strap_i,
    .fiber_signal_detect_i, .link_up_i, .speed100_i, .aneg_duplex_i,
    .mii_txd_i, .mii_tx_en_i, .mii_tx_er_i, .line_rxd_i, .line_rx_dv_i,
    .line_rx_er_i, .line_col_i, .mii_rxd_o, .mii_rx_dv_o, .mii_rx_er_o,
    .mii_crs_o, .mii_col_o, .mii_tx_clk_o, .mii_rx_clk_o, .mii_out_oe_n_o,
    .line_txd_o, .line_tx_en_o, .line_tx_pair_oe_n_o, .fx_mode_o,
    .nrzi_coding_o, .scrambler_bypass_o, .manchester_o, .serial_mode_o,
    .duplex_full_o, .soft_reset_o, .tx_activity_led_n_o,
    .tx_activity_led_oe_n_o, .rx_activity_led_n_o, .speed_led_n_o,
    .link_led_n_o, .collision_led_n_o);
  mac_model mac (.sys_clk_i, .rst_i(reset_i), .start_i(mac_start),
    .first_i(mac_first), .len_i(mac_len), .txd_o(mii_txd_i),
    .tx_en_o(mii_tx_en_i), .tx_er_o(mii_tx_er_i));
  // all led pins side by side
  assign leds = {tx_activity_led_n_o, rx_activity_led_n_o, speed_led_n_o,
                 link_led_n_o, collision_led_n_o};
  always #25 sys_clk_i = ~sys_clk_i;
  // cycle ceiling against hangs
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("mismatches %0d, compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input reg_addr_t a, input reg_data_t v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    tk(1);
  endtask
  task automatic rd(input reg_addr_t a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic frame(input logic [3:0] len);
    @(posedge sys_clk_i);
    mac_first <= 4'($urandom);
    mac_len <= len;
    mac_start <= 1'b1;
    @(posedge sys_clk_i);
    mac_start <= 1'b0;
  endtask
  // status bits one toggle of link (or speed) should leave
  function automatic logic [3:0] exp_st(input reg_data_t c, input logic sp);
    if (!c[14] || c[sp ? 10 : 11]) return 4'h0;
    return sp ? 4'h5 : 4'h9;
  endfunction
  initial begin
    seed = $urandom(77369);
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    // defaults, unmapped index, duplex choice
    rd(5'h00);
    chk(d, 16'h1000);
    rd(5'h04);
    chk(d & 16'h0140, 16'h0140);
    rd(5'h05);
    chk(d, 16'h0000);
    chk(16'(duplex_full_o), 16'h0);
    @(posedge sys_clk_i) aneg_duplex_i <= 1'b1;
    tk(1);
    chk(16'(duplex_full_o), 16'h1);
    wr(5'h04, 16'h0081);
    chk(16'(duplex_full_o), 16'h0);
    // isolate, super isolate, software reset
    wr(5'h00, 16'h1400);
    frame(4'h5);
    tk(3);
    chk(16'({mii_out_oe_n_o, line_tx_pair_oe_n_o, line_tx_en_o}), 16'h4);
    chk(16'(line_txd_o), 16'h0);
    wr(5'h1e, 16'h0008);
    chk(16'(line_tx_pair_oe_n_o), 16'h1);
    wr(5'h1e, 16'h0000);
    chk(16'({mii_out_oe_n_o, line_tx_pair_oe_n_o}), 16'h2);
    wr(5'h00, 16'h8000);
    rd(5'h00);
    chk(d, 16'h1000);
    chk(16'(mii_out_oe_n_o), 16'h0);
    // isolate, then a hardware reset of the minimum length clears it
    wr(5'h00, 16'h0400);
    @(posedge sys_clk_i) reset_i <= 1'b1;
    repeat (`RESET_MIN_CYC) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(5'h00);
    chk(d, 16'h1000);
    chk(16'(mii_out_oe_n_o), 16'h0);
    // forced full duplex, duplex led, transmit with random line collisions
    wr(5'h00, 16'h0100);
    rd(5'h18);
    chk(d & 16'h0001, 16'h0001);
    wr(5'h1a, 16'h8000);
    chk(16'(tx_activity_led_n_o), 16'h0);
    frame(4'h9);
    repeat (12) begin
      @(posedge sys_clk_i) line_col_i <= 1'($urandom);
      #1 chk(16'({mii_col_o, mii_crs_o}), 16'h0);
    end
    line_col_i <= 1'b0;
    wr(5'h00, 16'h0000);
    chk(16'(tx_activity_led_n_o), 16'h1);
    // collision test follows transmit enable
    wr(5'h00, 16'h0080);
    frame(4'h8);
    tk(3);
    chk(16'(mii_col_o), 16'h1);
    tk(12);
    chk(16'(mii_col_o), 16'h0);
    // loopback with line traffic present
    wr(5'h00, 16'h4000);
    line_rx_dv_i <= 1'b1;
    line_rx_er_i <= 1'b1;
    line_rxd_i <= 4'($urandom);
    frame(4'h6);
    for (i = 0; i < 8 && mii_rx_dv_o !== 1'b1; i++) tk(1);
    chk(16'({mii_rxd_o, line_tx_en_o, mii_rx_er_o}), 16'({mac_first, 2'b00}));
    line_rx_dv_i <= 1'b0;
    line_rx_er_i <= 1'b0;
    wr(5'h00, 16'h0000);
    // forced led modes
    wr(5'h1a, 16'h0010);
    chk(16'(leds), 16'h0000);
    wr(5'h1a, 16'h0020);
    chk(16'(leds), 16'h001f);
    // activity stretch, normal then traffic meter
    wr(5'h1a, 16'h0000);
    @(posedge sys_clk_i) link_up_i <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(5'h1b, i ? 16'h0040 : 16'h0000);
      frame(4'h2);
      tk(4);
      chk(16'(tx_activity_led_n_o), 16'h0);
      tk(PULSE * 2);
      chk(16'(tx_activity_led_n_o), 16'(i == 0));
      tk(PULSE * 9);
    end
    // interrupt enable, link source mask, global mask
    for (i = 0; i < 6; i++) begin
      wr(5'h1a, cfg[i]);
      rd(5'h1a);
      @(posedge sys_clk_i);
      if (i == 1) speed100_i <= ~speed100_i;
      else link_up_i <= ~link_up_i;
      tk(3);
      st = exp_st(cfg[i], i == 1);
      if (cfg[i][14]) chk(16'(tx_activity_led_oe_n_o), 16'(st == 0 || cfg[i][8]));
      rd(5'h1a);
      chk(d & 16'h000f, 16'(st));
      if (cfg[i][14]) chk(16'(tx_activity_led_oe_n_o), 16'h1);
    end
    // fiber detect, then 10M serial mode
    @(posedge sys_clk_i) fiber_signal_detect_i <= 1'b1;
    tk(5);
    chk(16'({fx_mode_o, nrzi_coding_o, scrambler_bypass_o}), 16'h7);
    @(posedge sys_clk_i) fiber_signal_detect_i <= 1'b0;
    speed100_i <= 1'b0;
    line_rxd_i <= 4'h7;
    tk(1);
    // 10M nibble clock: exactly two toggles in any eight cycles
    n = 0;
    for (i = 0; i < 8; i++) begin
      ck = mii_tx_clk_o;
      tk(1);
      n += int'(mii_tx_clk_o != ck);
    end
    chk(16'(n), 16'h2);
    wr(5'h1e, 16'h0002);
    tk(4);
    chk(16'({fx_mode_o, manchester_o, serial_mode_o}), 16'h3);
    chk(16'(mii_rxd_o), 16'h1);
    // serial clocks toggle every cycle, tx and rx both checked
    for (i = 0; i < 4; i++) begin
      ck = mii_tx_clk_o;
      tk(1);
      chk(16'({mii_tx_clk_o ^ ck, mii_rx_clk_o ^ ck}), 16'h3);
    end
    @(posedge sys_clk_i) speed100_i <= 1'b1;
    tk(1);
    chk(16'(serial_mode_o), 16'h0);
    test_done();
  end
endmodule
`default_nettype wire
